/* File: include/node_services_pkg.sv */
// Package for the CANopen node service block: constants, codes and carriers.
// Assumes a 200 MHz ref_clk and a CAN controller that moves frames outside.
package node_services_pkg;

  // ****************************************
  // Identifier bases and service codes
  // ****************************************
  localparam logic [10:0] EMCY_BASE_ID   = 11'h080;
  localparam logic [10:0] HBEAT_BASE_ID  = 11'h700;
  localparam logic [15:0] EC_NO_ERROR    = 16'h0000;
  localparam logic [15:0] EC_SENSOR      = 16'h5030;
  localparam logic [15:0] EC_COMM        = 16'h8100;
  localparam logic [15:0] EC_OVERRUN     = 16'h8110;
  localparam logic [15:0] EC_PASSIVE     = 16'h8120;
  localparam logic [15:0] EC_HB_MISS     = 16'h8130;
  localparam logic [15:0] EC_BUSOFF_REC  = 16'h8140;
  localparam logic [15:0] EC_ID_COLLIDE  = 16'h8150;
  localparam logic [15:0] AI_AD_WDOG     = 16'hC555;
  localparam logic [15:0] AI_BOND_WIRE   = 16'hCFCF;

  // ****************************************
  // Sizes and reset values
  // ****************************************
  localparam int          HIST_DEPTH     = 50;
  localparam int          USER_RATES     = 5;
  localparam int          STD_RATES      = 8;
  localparam logic [6:0]  NODE_ID_RST    = 7'h01;
  localparam logic [2:0]  RATE_CODE_RST  = 3'h2;
  localparam logic [7:0]  ERR_REG_RST    = 8'h00;
  localparam logic [31:0] TIME_RST       = 32'h0000_0000;
  localparam logic [15:0] HB_NMT_OPER    = 16'h0005;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ       = 200;
  localparam int MS_NS         = 1000000;
  localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

  // Standard rate table in kbit/s, code 0 first
  localparam logic [15:0] STD_KBPS [STD_RATES] = '{
    16'd1000, 16'd800, 16'd500, 16'd250, 16'd125, 16'd100, 16'd50, 16'd20
  };

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [15:0] code;
    logic [7:0]  err_reg;
    logic [15:0] info;
    logic [23:0] rsvd;
  } emcy_payload_type;

  typedef struct packed {
    logic        valid;
    logic [10:0] id;
    logic [3:0]  dlc;
    logic [63:0] data;
  } can_frame_type;

  typedef struct packed {
    logic comm;
    logic overrun;
    logic passive;
    logic hb_miss;
    logic busoff_rec;
    logic id_collide;
    logic ad_wdog;
    logic bond_wire;
    logic reset_ind;
  } err_events_type;

  typedef struct packed {
    logic [15:0] info;
    logic [15:0] code;
  } hist_entry_type;

endpackage

/* File: src/node_services.sv */
// CANopen node service logic: emergency, error history, time stamp,
// heartbeat producer/consumer and layer-setting of node id and bit rate.
// Assumes a CAN controller that takes one frame per tx_frame/tx_ready
// handshake and hands in decoded received frames as one-cycle pulses.
`timescale 1ns/1ps

module node_services #(
  parameter int          HIST_DEPTH = node_services_pkg::HIST_DEPTH,
  parameter int          USER_RATES = node_services_pkg::USER_RATES,
  parameter int          MS_CYCLES  = node_services_pkg::MS_CYCLES,
  parameter logic [79:0] USER_KBPS  = 80'h0000_0000_0000_0000_0000
) (
  input  wire logic                              ref_clk,       // 200 MHz clock
  input  wire logic                              rst_n,         // Sync reset, low
  input  wire node_services_pkg::err_events_type err_ev,        // Error event pulses
  input  wire logic [10:0]                       time_cob_id,   // Time frame id
  input  wire logic                              time_produce,  // Act as time producer
  input  wire logic                              time_consume,  // Act as time consumer
  input  wire logic                              time_send,     // Send time frame now
  input  wire logic                              time_rx,       // Time frame received
  input  wire logic [31:0]                       time_rx_ms,    // Received ms value
  input  wire logic [15:0]                       hb_prod_ms,    // Producer period, 0 off
  input  wire logic [15:0]                       hb_cons_ms,    // Consumer timeout, 0 off
  input  wire logic                              hb_rx,         // Watched node beat seen
  input  wire logic                              lss_id_set,    // Layer-set node id
  input  wire logic [6:0]                        lss_id,        // New node id
  input  wire logic                              lss_rate_set,  // Layer-set bit rate
  input  wire logic [7:0]                        lss_table,     // Table selector
  input  wire logic [7:0]                        lss_rate_code, // Rate code
  input  wire logic                              hist_clear,    // Zero written to count
  input  wire logic [5:0]                        hist_index,    // Entry to read, 1 based
  input  wire logic                              tx_ready,      // Controller takes frame
  output node_services_pkg::can_frame_type       tx_frame,      // Frame offered
  output logic [7:0]                             lss_status,    // 0 ok, 1 bad rate
  output logic [6:0]                             node_id,       // Active node id
  output logic [15:0]                            bit_rate_kbps, // Selected bit rate
  output logic [7:0]                             err_reg,       // Error register
  output logic [5:0]                             hist_count,    // History entries
  output node_services_pkg::hist_entry_type      hist_entry,    // Entry at hist_index
  output logic [31:0]                            time_stamp     // Mappable ms stamp
);

  // ****************************************
  // Millisecond tick and time stamp
  // ****************************************
  localparam int MSW = $clog2(MS_CYCLES + 1);

  logic [MSW-1:0] ms_cnt_r;
  logic [31:0]    time_r;
  wire            ms_tick = (ms_cnt_r == MSW'(MS_CYCLES - 1));

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ms_cnt_r <= '0;
    end else begin
      ms_cnt_r <= ms_tick ? '0 : ms_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      time_r <= node_services_pkg::TIME_RST;
    end else if (time_consume && time_rx) begin
      time_r <= time_rx_ms;
    end else if (ms_tick) begin
      time_r <= time_r + 32'h0000_0001;
    end
  end

  assign time_stamp = time_r;

  // ****************************************
  // Error events to emergency code
  // ****************************************
  // Several events in one cycle: only one can be reported, so a fixed
  // priority picks it; the others are pending until sent.
  logic [8:0] pend_r;
  logic       held_r;
  logic [3:0] held_sel_r;
  wire  [8:0] ev_vec = err_ev;

  function automatic logic [3:0] pick(input logic [8:0] v);
    pick = 4'hF;
    for (int i = 0; i < 9; i++) begin
      if (v[i]) pick = 4'(i);
    end
  endfunction

  wire [3:0] fresh_sel = pick(pend_r);
  wire [3:0] sel       = held_r ? held_sel_r : fresh_sel;

  logic [15:0] sel_code;
  logic [15:0] sel_info;
  always_comb begin
    sel_info = 16'h0000;
    case (sel)
      4'd8:    sel_code = node_services_pkg::EC_COMM;
      4'd7:    sel_code = node_services_pkg::EC_OVERRUN;
      4'd6:    sel_code = node_services_pkg::EC_PASSIVE;
      4'd5:    sel_code = node_services_pkg::EC_HB_MISS;
      4'd4:    sel_code = node_services_pkg::EC_BUSOFF_REC;
      4'd3:    sel_code = node_services_pkg::EC_ID_COLLIDE;
      4'd2: begin
        sel_code = node_services_pkg::EC_SENSOR;
        sel_info = node_services_pkg::AI_AD_WDOG;
      end
      4'd1: begin
        sel_code = node_services_pkg::EC_SENSOR;
        sel_info = node_services_pkg::AI_BOND_WIRE;
      end
      default: sel_code = node_services_pkg::EC_NO_ERROR;
    endcase
  end

  // ****************************************
  // Error register
  // ****************************************
  logic [7:0] err_reg_r;
  wire        ad_err = err_ev.ad_wdog | err_ev.bond_wire;
  wire        comm_err = |ev_vec[8:3];

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      err_reg_r <= node_services_pkg::ERR_REG_RST;
    end else begin
      // Generic bit is never cleared here; only power-up reset drops it
      err_reg_r[0] <= err_reg_r[0] | ad_err;
      err_reg_r[4] <= (err_reg_r[4] & ~err_ev.reset_ind) | comm_err;
    end
  end

  assign err_reg = err_reg_r;

  // ****************************************
  // Layer-setting: node id and bit rate
  // ****************************************
  logic [6:0]  node_id_r;
  logic [15:0] rate_r;
  logic [7:0]  lss_stat_r;
  wire         std_ok  = (lss_table == 8'h00) &&
                         (lss_rate_code < 8'(node_services_pkg::STD_RATES));
  wire         user_ok = (lss_table == 8'h01) && (lss_rate_code < 8'(USER_RATES));
  wire [15:0]  std_kbps = node_services_pkg::STD_KBPS[lss_rate_code[2:0]];
  wire [15:0]  user_kbps = USER_KBPS[16*lss_rate_code[2:0] +: 16];

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      node_id_r  <= node_services_pkg::NODE_ID_RST;
      rate_r     <= node_services_pkg::STD_KBPS[node_services_pkg::RATE_CODE_RST];
      lss_stat_r <= 8'h00;
    end else begin
      if (lss_id_set) begin
        node_id_r <= lss_id;
      end
      // A refused request keeps the old rate
      if (lss_rate_set) begin
        lss_stat_r <= (std_ok || user_ok) ? 8'h00 : 8'h01;
        if (std_ok) begin
          rate_r <= std_kbps;
        end else if (user_ok) begin
          rate_r <= user_kbps;
        end
      end
    end
  end

  assign node_id       = node_id_r;
  assign bit_rate_kbps = rate_r;
  assign lss_status    = lss_stat_r;

  // ****************************************
  // Heartbeat producer and consumer
  // ****************************************
  logic [15:0] hb_prod_cnt_r;
  logic [15:0] hb_cons_cnt_r;
  logic        hb_pend_r;
  logic        hb_armed_r;
  wire         hb_due = (hb_prod_ms != 16'h0000) && ms_tick &&
                        (hb_prod_cnt_r >= hb_prod_ms - 16'h0001);
  wire         hb_lost = hb_armed_r && (hb_cons_ms != 16'h0000) && ms_tick &&
                         (hb_cons_cnt_r >= hb_cons_ms - 16'h0001);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      hb_prod_cnt_r <= 16'h0000;
      hb_cons_cnt_r <= 16'h0000;
      hb_armed_r    <= 1'b0;
    end else begin
      if (hb_due || hb_prod_ms == 16'h0000) begin
        hb_prod_cnt_r <= 16'h0000;
      end else if (ms_tick) begin
        hb_prod_cnt_r <= hb_prod_cnt_r + 16'h0001;
      end
      // Armed by the first beat, so a node never heard is not reported
      if (hb_rx) begin
        hb_cons_cnt_r <= 16'h0000;
        hb_armed_r    <= 1'b1;
      end else if (hb_lost) begin
        hb_armed_r    <= 1'b0; // One report per loss
      end else if (ms_tick) begin
        hb_cons_cnt_r <= hb_cons_cnt_r + 16'h0001;
      end
    end
  end

  // ****************************************
  // Pending requests and transmit arbiter
  // ****************************************
  typedef enum logic [1:0] {SRC_NONE, SRC_EMCY, SRC_HB, SRC_TIME} src_type;

  logic tm_pend_r;
  logic [63:0] held_data_r;
  src_type     held_src_r;
  wire  [8:0] ev_in = ev_vec | {3'b000, hb_lost, 5'b00000};
  wire  emcy_want = (pend_r != 9'h000);
  src_type fresh_src;
  src_type src;
  assign fresh_src = emcy_want ? SRC_EMCY : hb_pend_r ? SRC_HB : tm_pend_r ? SRC_TIME : SRC_NONE;
  assign src       = held_r ? held_src_r : fresh_src;
  wire  taken = tx_ready && (src != SRC_NONE);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pend_r    <= 9'h000;
      hb_pend_r <= 1'b0;
      tm_pend_r <= 1'b0;
    end else begin
      // New event wins over the clear of the one being sent
      pend_r    <= (pend_r & ~((taken && src == SRC_EMCY) ? 9'(1) << sel : 9'h000)) | ev_in;
      hb_pend_r <= (hb_pend_r & ~(taken && src == SRC_HB)) | hb_due;
      tm_pend_r <= (tm_pend_r & ~(taken && src == SRC_TIME)) | (time_produce & time_send);
    end
  end

  node_services_pkg::emcy_payload_type emcy_pl;
  assign emcy_pl = '{code: sel_code, err_reg: err_reg_r, info: sel_info, rsvd: 24'h00_0000};

  always_comb begin
    tx_frame = '0;
    case (src)
      SRC_EMCY: begin
        tx_frame.valid = 1'b1;
        tx_frame.id    = node_services_pkg::EMCY_BASE_ID + {4'h0, node_id_r};
        tx_frame.dlc   = 4'h8;
        tx_frame.data  = emcy_pl;
      end
      SRC_HB: begin
        tx_frame.valid = 1'b1;
        tx_frame.id    = node_services_pkg::HBEAT_BASE_ID + {4'h0, node_id_r};
        tx_frame.dlc   = 4'h1;
        tx_frame.data  = {node_services_pkg::HB_NMT_OPER[7:0], 56'h0};
      end
      SRC_TIME: begin
        tx_frame.valid = 1'b1;
        // Id is set from outside, so a node id change leaves it alone
        tx_frame.id    = time_cob_id;
        tx_frame.dlc   = 4'h4;
        tx_frame.data  = {time_r, 32'h0000_0000};
      end
      default: tx_frame = '0;
    endcase
    if (held_r) begin
      tx_frame.data = held_data_r;
    end
  end

  // ****************************************
  // Offered frame held until taken
  // ****************************************
  // A later, higher-priority request or a time stamp tick must not change
  // a frame that the controller may already be putting on the bus.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      held_r      <= 1'b0;
      held_src_r  <= SRC_NONE;
      held_sel_r  <= 4'hF;
      held_data_r <= 64'h0000_0000_0000_0000;
    end else begin
      held_r      <= (src != SRC_NONE) && !tx_ready;
      held_src_r  <= src;
      held_sel_r  <= sel;
      held_data_r <= tx_frame.data;
    end
  end

  // ****************************************
  // Error history
  // ****************************************
  // Contents are not reset; a zero count hides stale entries
  node_services_pkg::hist_entry_type hist_r [HIST_DEPTH];
  logic [5:0] hist_cnt_r;
  wire        push = taken && (src == SRC_EMCY) && (sel_code != node_services_pkg::EC_NO_ERROR);

  always_ff @(posedge ref_clk) begin
    if (push) begin
      hist_r[0] <= '{info: sel_info, code: sel_code};
      for (int i = 1; i < HIST_DEPTH; i++) begin
        hist_r[i] <= hist_r[i-1];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      hist_cnt_r <= 6'h00;
    end else if (push) begin
      hist_cnt_r <= (hist_cnt_r == 6'(HIST_DEPTH)) ? hist_cnt_r : hist_cnt_r + 6'h01;
    end else if (hist_clear) begin
      hist_cnt_r <= 6'h00;
    end
  end

  wire idx_ok = (hist_index != 6'h00) && (hist_index <= hist_cnt_r);
  assign hist_count = hist_cnt_r;
  assign hist_entry = idx_ok ? hist_r[hist_index - 6'h01] : '0;

endmodule

/* File: testbench/can_ctrl_model.sv */
// Model of the CAN controller that takes frames from node_services.
// Assumes the bench sets the stall count between frames.
`timescale 1ns/1ps
module can_ctrl_model (
  input  wire logic       ref_clk,     // Clock
  input  wire logic       rst_n,       // Sync reset, low
  input  wire logic       frame_valid, // Frame offered
  input  wire logic [3:0] stall,       // Cycles to hold off
  output logic            tx_ready     // Frame taken
);
  // ****************************************
  // Take a frame after a variable delay
  // ****************************************
  logic [3:0] wait_r;

  always_ff @(posedge ref_clk) begin
    if (!rst_n || !frame_valid || tx_ready) begin
      wait_r <= 4'h0;
    end else begin
      wait_r <= wait_r + 4'h1;
    end
  end

  // Ready only while a frame stands, so a take always pairs with one frame
  assign tx_ready = frame_valid && (wait_r >= stall);
endmodule

/* File: testbench/node_services_monitor.sv */
// Checker for node_services: frame timing, identifiers and layer-setting.
// Sees only the top module ports; bound after the module.
`timescale 1ns/1ps
module node_services_monitor (
  input wire logic                              ref_clk,       // Clock
  input wire logic                              rst_n,         // Reset, low
  input wire node_services_pkg::err_events_type err_ev,        // Error pulses
  input wire logic                              lss_id_set,    // Id request
  input wire logic [6:0]                        lss_id,        // New id
  input wire logic                              lss_rate_set,  // Rate request
  input wire logic [7:0]                        lss_table,     // Table selector
  input wire logic [7:0]                        lss_rate_code, // Rate code
  input wire logic                              hist_clear,    // History erase
  input wire logic                              tx_ready,      // Frame taken
  input wire node_services_pkg::can_frame_type  tx_frame,      // Frame offered
  input wire logic [7:0]                        lss_status,    // Rate status
  input wire logic [6:0]                        node_id,       // Node id
  input wire logic [15:0]                       bit_rate_kbps, // Bit rate
  input wire logic [7:0]                        err_reg,       // Error register
  input wire logic [5:0]                        hist_count     // History count
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_emcy_prompt: assert property ((|err_ev) && !tx_frame.valid |=> tx_frame.valid)
    else $error("No frame after error event");
  a_frame_hold: assert property (tx_frame.valid && !tx_ready |=> $stable(tx_frame))
    else $error("Frame changed before taken");
  a_emcy_ident: assert property (tx_frame.valid && tx_frame.dlc == 4'h8 |->
    tx_frame.id == node_services_pkg::EMCY_BASE_ID + 11'(node_id))
    else $error("Emergency identifier wrong");
  a_emcy_rsvd: assert property (tx_frame.valid && tx_frame.dlc == 4'h8 |->
    tx_frame.data[23:0] == 24'h00_0000)
    else $error("Reserved bytes not zero");
  a_hb_fixed: assert property (tx_frame.valid && tx_frame.dlc == 4'h1 |->
    tx_frame.id == node_services_pkg::HBEAT_BASE_ID + 11'(node_id) &&
    tx_frame.data[63:56] == 8'h05)
    else $error("Heartbeat frame wrong");
  a_std_rate: assert property (lss_rate_set && lss_table == 8'h00 && lss_rate_code < 8'h08
    |=> bit_rate_kbps == node_services_pkg::STD_KBPS[$past(lss_rate_code[2:0])] &&
    lss_status == 8'h00)
    else $error("Standard rate not applied");
  a_rate_reject: assert property (lss_rate_set && lss_table > 8'h01
    |=> $stable(bit_rate_kbps) && lss_status == 8'h01)
    else $error("Bad table not refused");
  a_id_take: assert property (lss_id_set |=> node_id == $past(lss_id))
    else $error("Node id not taken");
  a_gen_sticky: assert property (err_reg[0] |=> err_reg[0])
    else $error("Generic error bit cleared");
  a_hist_erase: assert property (hist_clear && !(tx_frame.valid && tx_ready)
    |=> hist_count == 6'h00)
    else $error("History not erased");

  c_emcy: cover property (tx_frame.valid && tx_ready && tx_frame.dlc == 4'h8);
  c_hbeat: cover property (tx_frame.valid && tx_ready && tx_frame.dlc == 4'h1);
  c_rate: cover property (lss_rate_set && lss_table == 8'h01);
endmodule

bind node_services node_services_monitor u_mon (.ref_clk, .rst_n, .err_ev, .lss_id_set,
  .lss_id, .lss_rate_set, .lss_table, .lss_rate_code, .hist_clear, .tx_ready, .tx_frame,
  .lss_status, .node_id, .bit_rate_kbps, .err_reg, .hist_count);

/* File: testbench/tb_top.sv */
// Self-checking bench for node_services with a CAN controller model.
// Assumes a millisecond of 10 cycles and a known user rate table.
`timescale 1ns/1ps
module tb_top;
  // ****************************************
  // Signals and design
  // ****************************************
  localparam logic [79:0] UK = 80'h0046_003C_0028_001E_000A;
  logic ref_clk = 0, rst_n = 0, tx_ready, time_produce = 0, time_consume = 0;
  logic time_send = 0, time_rx = 0, hb_rx = 0, lss_id_set = 0, lss_rate_set = 0;
  logic hist_clear = 0;
  node_services_pkg::err_events_type err_ev = '0, e;
  node_services_pkg::can_frame_type  tx_frame;
  node_services_pkg::hist_entry_type hist_entry;
  logic [10:0] time_cob_id = 11'h100;
  logic [31:0] time_rx_ms = '0, time_stamp, v;
  logic [15:0] hb_prod_ms = '0, hb_cons_ms = '0, bit_rate_kbps;
  logic [6:0]  lss_id = '0, node_id, nid = 7'h01;
  logic [7:0]  lss_table = '0, lss_rate_code = '0, lss_status, err_reg;
  logic [5:0]  hist_index = 6'h01, hist_count;
  logic [3:0]  stall = '0;
  logic [79:0] exp_q[$], msk_q[$], m;
  logic [15:0] codes[8] = '{node_services_pkg::EC_COMM, node_services_pkg::EC_OVERRUN,
    node_services_pkg::EC_PASSIVE, node_services_pkg::EC_HB_MISS,
    node_services_pkg::EC_BUSOFF_REC, node_services_pkg::EC_ID_COLLIDE,
    node_services_pkg::EC_SENSOR, node_services_pkg::EC_SENSOR};
  int n_fail = 0, n_tests = 0, seed = 90918, i;

  node_services #(.MS_CYCLES(10), .USER_KBPS(UK)) u_node_services (.ref_clk, .rst_n, .err_ev,
    .time_cob_id, .time_produce, .time_consume, .time_send, .time_rx, .time_rx_ms,
    .hb_prod_ms, .hb_cons_ms, .hb_rx, .lss_id_set, .lss_id, .lss_rate_set, .lss_table,
    .lss_rate_code, .hist_clear, .hist_index, .tx_ready, .tx_frame, .lss_status,
    .node_id, .bit_rate_kbps, .err_reg, .hist_count, .hist_entry, .time_stamp);
  can_ctrl_model u_can_ctrl_model (.ref_clk, .rst_n, .frame_valid(tx_frame.valid), .stall,
    .tx_ready);

  initial forever #2.5 ref_clk = ~ref_clk;

  // ****************************************
  // Tasks
  // ****************************************
  task step(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task chk(logic [79:0] got, logic [79:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task give_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task expect_frame(logic [10:0] id, logic [3:0] dlc, logic [63:0] d, logic [63:0] dm);
    exp_q.push_back({1'b1, id, dlc, d});
    msk_q.push_back({16'hFFFF, dm});
  endtask
  task emcy(logic [15:0] c, logic [15:0] inf, logic im, logic b, logic bm);
    expect_frame(11'h080 + 11'(nid), 4'h8, {c, 7'h00, b, inf, 24'h00_0000},
      {16'hFFFF, 7'h00, bm, {16{im}}, 24'hFF_FFFF});
  endtask
  task drain;
    for (int k = 0; k < 300 && exp_q.size() != 0; k++) step(1);
    if (exp_q.size() != 0) begin
      n_fail++;
      $display("CHECK FAILED at %0t: frame never taken", $time);
      give_verdict;
    end
  endtask
  task ev(node_services_pkg::err_events_type x);
    err_ev <= x;
    step(1);
    err_ev <= '0;
    drain;
  endtask
  task rate(logic [7:0] t, logic [7:0] c, logic [15:0] k, logic [7:0] s);
    lss_table <= t;
    lss_rate_code <= c;
    lss_rate_set <= 1'b1;
    step(1);
    lss_rate_set <= 1'b0;
    step(1);
    chk(bit_rate_kbps, k);
    chk(lss_status, s);
  endtask

  // ****************************************
  // Frame watcher and stimulus
  // ****************************************
  always @(negedge ref_clk) begin
    if (rst_n && tx_frame.valid && tx_ready) begin
      if (exp_q.size() == 0) chk(tx_frame, '0);
      else begin
        m = msk_q.pop_front();
        chk(tx_frame & m, exp_q.pop_front() & m);
      end
    end
  end

  // New hold-off only after the take edge, so ready cannot drop mid-cycle
  always @(posedge ref_clk) begin
    if (rst_n && tx_frame.valid && tx_ready) stall <= 4'($random(seed));
  end

  initial begin
    step(6);
    rst_n <= 1'b1;
    step(1);
    chk(node_id, node_services_pkg::NODE_ID_RST);
    chk(bit_rate_kbps, 16'h01F4);
    for (i = 0; i < 8; i++) begin
      e = '0;
      e[8-i] = 1'b1;
      emcy(codes[i], (i == 6) ? 16'hC555 : (i == 7) ? 16'hCFCF : 16'h0000,
        1'b1, i > 5, 1'b1);
      ev(e);
    end
    chk(hist_count, 6'h08);
    chk(hist_entry, {16'hCFCF, 16'h5030});
    hist_index <= 6'h02;
    step(1);
    chk(hist_entry, {16'hC555, 16'h5030});
    e = '0;
    e.comm = 1'b1;
    e.passive = 1'b1;
    emcy(16'h8100, '0, 1'b1, 1'b1, 1'b1);
    emcy(16'h8120, '0, 1'b1, 1'b1, 1'b1);
    ev(e);
    chk(hist_entry, {16'h0000, 16'h8100});
    e = '0;
    e.reset_ind = 1'b1;
    emcy(16'h0000, '0, 1'b1, 1'b1, 1'b1);
    ev(e);
    chk(err_reg[0], 1'b1);
    chk(hist_count, 6'h0A);
    hist_clear <= 1'b1;
    step(1);
    hist_clear <= 1'b0;
    step(1);
    chk(hist_count, 6'h00);
    nid = 7'($random(seed)) | 7'h02;
    lss_id <= nid;
    lss_id_set <= 1'b1;
    step(1);
    lss_id_set <= 1'b0;
    step(1);
    chk(node_id, nid);
    e = '0;
    e.overrun = 1'b1;
    emcy(16'h8110, '0, 1'b1, 1'b1, 1'b1);
    ev(e);
    for (i = 0; i < 8; i++) rate(8'h00, 8'(i), node_services_pkg::STD_KBPS[i], 8'h00);
    for (i = 0; i < 5; i++) rate(8'h01, 8'(i), UK[16*i +: 16], 8'h00);
    rate(8'h01, 8'h05, UK[79:64], 8'h01);
    rate(8'h02, 8'h00, UK[79:64], 8'h01);
    rate(8'h00, 8'h08, UK[79:64], 8'h01);
    // Period of one short millisecond; switched off right after the first beat
    expect_frame(11'h700 + 11'(nid), 4'h1, {8'h05, 56'h0}, {8'hFF, 56'h0});
    hb_prod_ms <= 16'h0001;
    // Off as soon as the beat is offered, so a later tick adds none
    for (int k = 0; k < 40 && !tx_frame.valid; k++) step(1);
    hb_prod_ms <= 16'h0000;
    drain;
    emcy(16'h8130, '0, 1'b1, 1'b1, 1'b1);
    hb_cons_ms <= 16'h0002;
    hb_rx <= 1'b1;
    step(1);
    hb_rx <= 1'b0;
    drain;
    step(40);
    hb_cons_ms <= 16'h0000;
    time_produce <= 1'b1;
    expect_frame(11'h100, 4'h4, '0, {32'h0000_0000, 32'hFFFF_FFFF});
    time_send <= 1'b1;
    step(1);
    time_send <= 1'b0;
    drain;
    v = $random(seed);
    time_rx_ms <= v;
    time_consume <= 1'b1;
    time_rx <= 1'b1;
    step(1);
    time_rx <= 1'b0;
    step(1);
    chk(32'(time_stamp - v) < 32'h2, 1'b1);
    step(25);
    chk(32'(time_stamp - v) inside {[2:4]}, 1'b1);
    give_verdict;
  end
endmodule
